//--- mgr_pkg.sv
package mgr_pkg;
   // -------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------
   localparam int          IDX_W              = 7;
   localparam int          DATA_W             = 16;
   localparam logic [6:0]  IDX_MIC_GAIN       = 7'h0E;
   localparam logic [6:0]  IDX_LINE_GAIN      = 7'h10;
   localparam logic [6:0]  IDX_DISC_GAIN      = 7'h12;
   localparam logic [6:0]  IDX_PCM_GAIN       = 7'h18;
   localparam logic [6:0]  IDX_REC_SEL        = 7'h1A;

   localparam logic [15:0] RST_MIC_GAIN       = 16'h8008;
   localparam logic [15:0] RST_STEREO_GAIN    = 16'h8808;
   localparam logic [15:0] RST_REC_SEL        = 16'h0000;

   localparam logic [15:0] MASK_MIC_GAIN      = 16'h805F;
   localparam logic [15:0] MASK_STEREO_GAIN   = 16'h9F1F;
   localparam logic [15:0] MASK_REC_SEL       = 16'h0707;

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int          POS_MUTE           = 15;
   localparam int          POS_BOOST          = 6;
   localparam int          POS_LEFT_GAIN      = 8;
   localparam int          POS_RIGHT_GAIN     = 0;
   localparam int          GAIN_W             = 5;
   localparam int          POS_LEFT_SRC       = 8;
   localparam int          POS_RIGHT_SRC      = 0;
   localparam int          SRC_W              = 3;

   // -------------------------------------------------------------------
   // gain law, in half-dB units
   // -------------------------------------------------------------------
   localparam int          HDB_W              = 8;
   localparam logic [7:0]  HDB_TOP            = 8'h18;
   localparam logic [7:0]  HDB_STEP           = 8'h03;
   localparam logic [7:0]  HDB_BOOST          = 8'h28;
   localparam logic [7:0]  HDB_RESET          = 8'h00;

   // -------------------------------------------------------------------
   // record sources
   // -------------------------------------------------------------------
   localparam int          NUM_SRC            = 8;
   localparam logic [2:0]  SRC_MIC            = 3'h0;
   localparam logic [2:0]  SRC_DISC           = 3'h1;
   localparam logic [2:0]  SRC_BAD_A          = 3'h2;
   localparam logic [2:0]  SRC_BAD_B          = 3'h3;
   localparam logic [2:0]  SRC_LINE           = 3'h4;
   localparam logic [2:0]  SRC_STEREO_MIX     = 3'h5;
   localparam logic [2:0]  SRC_MONO_MIX       = 3'h6;
   localparam logic [2:0]  SRC_PCM            = 3'h7;

   localparam int          NUM_CHAN           = 7;
endpackage : mgr_pkg

//--- mgr_gain_chan.sv
module mgr_gain_chan
   import mgr_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic                     mute,
   input  wire logic [GAIN_W-1:0]        code,
   input  wire logic                     boost,
   output logic                          mute_ff,
   output logic signed [HDB_W-1:0]       gain_hdb_ff
);
   logic [HDB_W-1:0] nxt_gain;

   // code 0 is +12 dB, each step drops 1.5 dB; boost lifts 20 dB
   always_comb begin
      nxt_gain = HDB_TOP - HDB_STEP * HDB_W'(code);
      if (boost) begin
         nxt_gain = nxt_gain + HDB_BOOST;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mute_ff     <= 1'b1;
         gain_hdb_ff <= HDB_RESET;
      end else begin
         mute_ff     <= mute;
         gain_hdb_ff <= nxt_gain;
      end
   end
endmodule // mgr_gain_chan

//--- mgr_regs.sv
module mgr_regs
   import mgr_pkg::*;
(
   input  wire logic                           mclk,
   input  wire logic                           rst,
   input  wire logic                           reg_wr_en,
   input  wire logic                           reg_rd_en,
   input  wire logic [IDX_W-1:0]               reg_index,
   input  wire logic [DATA_W-1:0]              reg_wdata,
   output logic [DATA_W-1:0]                   reg_rdata_ff,
   output logic                                reg_rd_valid_ff,
   output logic [NUM_CHAN-1:0]                 chan_mute_ff,
   output logic [NUM_CHAN-1:0][HDB_W-1:0]      chan_gain_hdb_ff,
   output logic [NUM_SRC-1:0]                  left_route_ff,
   output logic [NUM_SRC-1:0]                  right_route_ff
);
   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   function automatic logic [NUM_SRC-1:0] route_of(input logic [SRC_W-1:0] sel);
      logic [NUM_SRC-1:0] r;
      r = '0;
      if (sel != SRC_BAD_A && sel != SRC_BAD_B) begin
         r[sel] = 1'b1;
      end
      return r;
   endfunction

   function automatic logic [DATA_W-1:0] mask_of(input logic [IDX_W-1:0] idx);
      logic [DATA_W-1:0] m;
      m = '0;
      unique case (idx)
         IDX_MIC_GAIN:  m = MASK_MIC_GAIN;
         IDX_LINE_GAIN,
         IDX_DISC_GAIN,
         IDX_PCM_GAIN:  m = MASK_STEREO_GAIN;
         IDX_REC_SEL:   m = MASK_REC_SEL;
         default:       m = '0;
      endcase
      return m;
   endfunction

   // -------------------------------------------------------------------
   // register storage
   // -------------------------------------------------------------------
   logic [DATA_W-1:0] mic_gain_ff;
   logic [DATA_W-1:0] line_gain_ff;
   logic [DATA_W-1:0] disc_gain_ff;
   logic [DATA_W-1:0] pcm_gain_ff;
   logic [DATA_W-1:0] rec_sel_ff;
   logic [DATA_W-1:0] wr_val;

   // reserved positions are never stored, so they cannot read back
   assign wr_val = reg_wdata & mask_of(reg_index);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mic_gain_ff  <= RST_MIC_GAIN;      // muted, 0 dB, no boost
         line_gain_ff <= RST_STEREO_GAIN;
         disc_gain_ff <= RST_STEREO_GAIN;
         pcm_gain_ff  <= RST_STEREO_GAIN;
         rec_sel_ff   <= RST_REC_SEL;
      end else if (reg_wr_en) begin
         if (reg_index == IDX_MIC_GAIN) begin
            mic_gain_ff <= wr_val;
         end
         if (reg_index == IDX_LINE_GAIN) begin
            line_gain_ff <= wr_val;
         end
         if (reg_index == IDX_DISC_GAIN) begin
            disc_gain_ff <= wr_val;
         end
         if (reg_index == IDX_PCM_GAIN) begin
            pcm_gain_ff <= wr_val;
         end
         if (reg_index == IDX_REC_SEL) begin
            rec_sel_ff <= wr_val;           // bad codes kept as written
         end
      end
   end

   // -------------------------------------------------------------------
   // read port
   // -------------------------------------------------------------------
   logic [DATA_W-1:0] nxt_rdata;

   // unmapped indices answer zero rather than stale data
   always_comb begin
      nxt_rdata = '0;
      unique case (reg_index)
         IDX_MIC_GAIN:  nxt_rdata = mic_gain_ff;
         IDX_LINE_GAIN: nxt_rdata = line_gain_ff;
         IDX_DISC_GAIN: nxt_rdata = disc_gain_ff;
         IDX_PCM_GAIN:  nxt_rdata = pcm_gain_ff;
         IDX_REC_SEL:   nxt_rdata = rec_sel_ff;
         default:       nxt_rdata = '0;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata_ff    <= '0;
         reg_rd_valid_ff <= 1'b0;
      end else begin
         reg_rd_valid_ff <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rdata_ff <= nxt_rdata & mask_of(reg_index);
         end
      end
   end

   // -------------------------------------------------------------------
   // gain channels: 0 mic, 1/2 line l/r, 3/4 cd l/r, 5/6 pcm l/r
   // -------------------------------------------------------------------
   logic [NUM_CHAN-1:0]             ch_mute;
   logic [NUM_CHAN-1:0]             ch_boost;
   logic [NUM_CHAN-1:0][GAIN_W-1:0] ch_code;

   // one mute bit covers both sides of a stereo pair
   assign ch_mute = {pcm_gain_ff[POS_MUTE],  pcm_gain_ff[POS_MUTE],
                     disc_gain_ff[POS_MUTE], disc_gain_ff[POS_MUTE],
                     line_gain_ff[POS_MUTE], line_gain_ff[POS_MUTE],
                     mic_gain_ff[POS_MUTE]};

   assign ch_boost = {{(NUM_CHAN-1){1'b0}}, mic_gain_ff[POS_BOOST]};

   assign ch_code = {pcm_gain_ff[POS_RIGHT_GAIN +: GAIN_W],
                     pcm_gain_ff[POS_LEFT_GAIN +: GAIN_W],
                     disc_gain_ff[POS_RIGHT_GAIN +: GAIN_W],
                     disc_gain_ff[POS_LEFT_GAIN +: GAIN_W],
                     line_gain_ff[POS_RIGHT_GAIN +: GAIN_W],
                     line_gain_ff[POS_LEFT_GAIN +: GAIN_W],
                     mic_gain_ff[POS_RIGHT_GAIN +: GAIN_W]};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
         // gain law shared by every channel
         mgr_gain_chan u_chan (
            .mclk        (mclk),
            .rst         (rst),
            .mute        (ch_mute[gi]),
            .code        (ch_code[gi]),
            .boost       (ch_boost[gi]),
            .mute_ff     (chan_mute_ff[gi]),
            .gain_hdb_ff (chan_gain_hdb_ff[gi])
         );
      end
   endgenerate

   // -------------------------------------------------------------------
   // record source routing
   // -------------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         left_route_ff  <= NUM_SRC'(1);
         right_route_ff <= NUM_SRC'(1);
      end else begin
         left_route_ff  <= route_of(rec_sel_ff[POS_LEFT_SRC +: SRC_W]);
         right_route_ff <= route_of(rec_sel_ff[POS_RIGHT_SRC +: SRC_W]);
      end
   end

   // -------------------------------------------------------------------
   // elaboration checks
   // -------------------------------------------------------------------
   // one route bit per select code, or codes would alias
   if ((1 << SRC_W) != NUM_SRC) begin : g_bad_src_count
      $error("route width does not match select width");
   end

   if (POS_RIGHT_SRC + SRC_W > POS_LEFT_SRC ||
       POS_LEFT_SRC + SRC_W > DATA_W) begin : g_bad_src_pos
      $error("record select fields overlap or leave the word");
   end

   if (POS_RIGHT_GAIN + GAIN_W > POS_LEFT_GAIN ||
       POS_LEFT_GAIN + GAIN_W > POS_MUTE) begin : g_bad_gain_pos
      $error("gain fields overlap each other or the mute bit");
   end

   if (POS_MUTE >= DATA_W) begin : g_bad_mute_pos
      $error("mute bit lies outside the register word");
   end

   // boost sits between the mic gain field and the mute bit
   if (POS_BOOST < POS_RIGHT_GAIN + GAIN_W ||
       POS_BOOST >= POS_MUTE) begin : g_bad_boost_pos
      $error("boost bit collides with another mic field");
   end

   // gain word is signed: boosted top and lowest code must both fit
   if (int'(HDB_TOP) + int'(HDB_BOOST) >= 2 ** (HDB_W - 1)) begin : g_bad_gain_top
      $error("boosted top gain overflows the gain word");
   end

   if (int'(HDB_STEP) * (2 ** GAIN_W - 1) - int'(HDB_TOP) >
       2 ** (HDB_W - 1)) begin : g_bad_gain_floor
      $error("lowest gain code underflows the gain word");
   end

   // gain shown during reset must equal the law at the reset codes
   if (HDB_W'(HDB_TOP - HDB_STEP * RST_MIC_GAIN[POS_RIGHT_GAIN +: GAIN_W]) !=
       HDB_RESET ||
       HDB_W'(HDB_TOP - HDB_STEP * RST_STEREO_GAIN[POS_LEFT_GAIN +: GAIN_W]) !=
       HDB_RESET) begin : g_bad_gain_reset
      $error("reset gain disagrees with the gain law");
   end

   if (MASK_MIC_GAIN[POS_MUTE] != 1'h1 || MASK_STEREO_GAIN[POS_MUTE] != 1'h1 ||
       MASK_MIC_GAIN[POS_BOOST] != 1'h1) begin : g_bad_mask_bits
      $error("a register mask drops a control bit");
   end

   if (MASK_MIC_GAIN[POS_RIGHT_GAIN +: GAIN_W] != '1 ||
       MASK_STEREO_GAIN[POS_LEFT_GAIN +: GAIN_W] != '1 ||
       MASK_STEREO_GAIN[POS_RIGHT_GAIN +: GAIN_W] != '1 ||
       MASK_REC_SEL[POS_LEFT_SRC +: SRC_W] != '1 ||
       MASK_REC_SEL[POS_RIGHT_SRC +: SRC_W] != '1) begin : g_bad_mask_fields
      $error("a register mask cuts into a field");
   end

   // a reserved bit set at reset would be stored, though the read mask hides it
   if ((RST_MIC_GAIN & ~MASK_MIC_GAIN) != '0 ||
       (RST_STEREO_GAIN & ~MASK_STEREO_GAIN) != '0 ||
       (RST_REC_SEL & ~MASK_REC_SEL) != '0) begin : g_bad_reset_mask
      $error("a reset value sets a reserved bit");
   end
endmodule // mgr_regs

//--- mgr_regs_properties.sv
// ----
// register bank properties
// ----
module mgr_regs_chk
   import mgr_pkg::*;
(
   input wire logic                           mclk,
   input wire logic                           rst,
   input wire logic                           reg_wr_en,
   input wire logic                           reg_rd_en,
   input wire logic [IDX_W-1:0]               reg_index,
   input wire logic [DATA_W-1:0]              reg_wdata,
   input wire logic [DATA_W-1:0]              reg_rdata_ff,
   input wire logic                           reg_rd_valid_ff,
   input wire logic [NUM_CHAN-1:0]            chan_mute_ff,
   input wire logic [NUM_CHAN-1:0][HDB_W-1:0] chan_gain_hdb_ff,
   input wire logic [NUM_SRC-1:0]             left_route_ff,
   input wire logic [NUM_SRC-1:0]             right_route_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // 7'h00 is no register, so it marks a cycle without a write
   wire [IDX_W-1:0] wi = reg_wr_en ? reg_index : 7'h00;

   a_mic_mute: assert property (wi == IDX_MIC_GAIN |-> ##2
      chan_mute_ff[0] == $past(reg_wdata[15], 2)) else $error("mic mute wrong");
   a_mic_gain: assert property (wi == IDX_MIC_GAIN |-> ##2 chan_gain_hdb_ff[0] ==
      8'(24 - 3 * $past(reg_wdata[4:0], 2) + ($past(reg_wdata[6], 2) ? 40 : 0)))
      else $error("mic gain wrong");
   a_line_mute: assert property (wi == IDX_LINE_GAIN |-> ##2
      chan_mute_ff[2:1] == {2{$past(reg_wdata[15], 2)}}) else $error("line mute wrong");
   a_line_gain: assert property (wi == IDX_LINE_GAIN |-> ##2 chan_gain_hdb_ff[2:1] ==
      {8'(24 - 3 * $past(reg_wdata[4:0], 2)), 8'(24 - 3 * $past(reg_wdata[12:8], 2))})
      else $error("line gain wrong");
   a_disc_mute: assert property (wi == IDX_DISC_GAIN |-> ##2
      chan_mute_ff[4:3] == {2{$past(reg_wdata[15], 2)}}) else $error("disc mute wrong");
   a_disc_gain: assert property (wi == IDX_DISC_GAIN |-> ##2 chan_gain_hdb_ff[4:3] ==
      {8'(24 - 3 * $past(reg_wdata[4:0], 2)), 8'(24 - 3 * $past(reg_wdata[12:8], 2))})
      else $error("disc gain wrong");
   a_pcm_mute: assert property (wi == IDX_PCM_GAIN |-> ##2
      chan_mute_ff[6:5] == {2{$past(reg_wdata[15], 2)}}) else $error("pcm mute wrong");
   a_pcm_gain: assert property (wi == IDX_PCM_GAIN |-> ##2 chan_gain_hdb_ff[6:5] ==
      {8'(24 - 3 * $past(reg_wdata[4:0], 2)), 8'(24 - 3 * $past(reg_wdata[12:8], 2))})
      else $error("pcm gain wrong");
   a_left_route: assert property (wi == IDX_REC_SEL |-> ##2 left_route_ff ==
      ($past(reg_wdata[10:9], 2) == 2'b01 ? 8'h00 : 8'h01 << $past(reg_wdata[10:8], 2)))
      else $error("left route wrong");
   a_right_route: assert property (wi == IDX_REC_SEL |-> ##2 right_route_ff ==
      ($past(reg_wdata[2:1], 2) == 2'b01 ? 8'h00 : 8'h01 << $past(reg_wdata[2:0], 2)))
      else $error("right route wrong");
   a_unmapped_read: assert property (reg_rd_en && reg_index == 7'h14 |=>
      reg_rd_valid_ff && reg_rdata_ff == 16'h0000) else $error("unmapped read wrong");
   a_resv_zero: assert property (reg_rd_valid_ff |->
      (reg_rdata_ff & 16'h60A0) == 16'h0000) else $error("reserved bits set");
endmodule // mgr_regs_chk

bind mgr_regs mgr_regs_chk u_mgr_regs_chk (.mclk, .rst, .reg_wr_en, .reg_rd_en, .reg_index,
   .reg_wdata, .reg_rdata_ff, .reg_rd_valid_ff, .chan_mute_ff, .chan_gain_hdb_ff,
   .left_route_ff, .right_route_ff);

//--- mgr_host.sv
// ----
// host side register master
// ----
module mgr_host
   import mgr_pkg::*;
(
   input  wire logic              mclk,
   output logic                   reg_wr_en,
   output logic                   reg_rd_en,
   output logic [IDX_W-1:0]       reg_index,
   output logic [DATA_W-1:0]      reg_wdata,
   input  wire logic [DATA_W-1:0] reg_rdata_ff,
   input  wire logic              reg_rd_valid_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {reg_wr_en, reg_rd_en, reg_index, reg_wdata} = '0;
   task automatic wr(input logic [6:0] i, input logic [15:0] d);
      @(posedge mclk);
      {reg_wr_en, reg_index, reg_wdata} <= {1'b1, i, d};
      @(posedge mclk);
      // idle data shows junk so a stale word cannot pass for a write
      {reg_wr_en, reg_wdata} <= {1'b0, ~d};
   endtask
   task automatic rd(input logic [6:0] i, output logic [15:0] d, output logic v);
      @(posedge mclk);
      {reg_rd_en, reg_index} <= {1'b1, i};
      @(posedge mclk);
      {reg_rd_en, reg_index} <= {1'b0, ~i};
      #1;
      {d, v} = {reg_rdata_ff, reg_rd_valid_ff};
   endtask
endmodule // mgr_host

//--- tb_top.sv
// ----
// self-checking bench
// ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import mgr_pkg::*;
   logic                           mclk = 1'b0, rst = 1'b1, vld;
   logic                           reg_wr_en, reg_rd_en, reg_rd_valid_ff;
   logic [IDX_W-1:0]               reg_index;
   logic [DATA_W-1:0]              reg_wdata, reg_rdata_ff, got;
   logic [NUM_CHAN-1:0]            chan_mute_ff;
   logic [NUM_CHAN-1:0][HDB_W-1:0] chan_gain_hdb_ff;
   logic [NUM_SRC-1:0]             left_route_ff, right_route_ff;
   int                             fails = 0, checks_done = 0, seed = 85, k, m[5];
   int                             msk[5] = '{16'h805F, 16'h9F1F, 16'h9F1F, 16'h9F1F, 16'h0707};
   logic [6:0]                     idx_tab[6] = '{IDX_MIC_GAIN, IDX_LINE_GAIN, IDX_DISC_GAIN,
                                                  IDX_PCM_GAIN, IDX_REC_SEL, 7'h14};
   mgr_regs u_mgr_regs (.mclk, .rst, .reg_wr_en, .reg_rd_en, .reg_index, .reg_wdata,
      .reg_rdata_ff, .reg_rd_valid_ff, .chan_mute_ff, .chan_gain_hdb_ff, .left_route_ff,
      .right_route_ff);
   mgr_host u_mgr_host (.mclk, .reg_wr_en, .reg_rd_en, .reg_index, .reg_wdata, .reg_rdata_ff,
      .reg_rd_valid_ff);
   initial forever #25 mclk = ~mclk;
   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] route(int c);
      return (c == 2 || c == 3) ? 8'h00 : 8'h01 << c;
   endfunction
   task automatic outs;
      chk(chan_mute_ff[0], m[0][15]);
      chk(chan_gain_hdb_ff[0], {8'(24 - 3 * (m[0] & 31) + (m[0][6] ? 40 : 0))});
      for (int c = 1; c < 4; c++) begin
         chk(chan_mute_ff[2*c-1 +: 2], {2{m[c][15]}});
         chk({chan_gain_hdb_ff[2*c], chan_gain_hdb_ff[2*c-1]},
             {8'(24 - 3 * (m[c] & 31)), 8'(24 - 3 * (m[c] >> 8 & 31))});
      end
      chk(left_route_ff, route(m[4] >> 8 & 7));
      chk(right_route_ff, route(m[4] & 7));
   endtask
   task automatic put(int i, logic [15:0] d);
      u_mgr_host.wr(idx_tab[i], d);
      if (i < 5) m[i] = d & msk[i];
      @(posedge mclk);
      #1;
      outs();
   endtask
   task automatic get(int i);
      u_mgr_host.rd(idx_tab[i], got, vld);
      chk(vld, 1'b1);
      chk(got, i < 5 ? m[i] : 0);
   endtask
   task automatic results;
      if (fails == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      m = '{16'h8008, 16'h8808, 16'h8808, 16'h8808, 16'h0000};
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      for (k = 0; k < 6; k++) get(k);
      put(0, 16'hFFFF);
      put(0, 16'h005F);
      put(1, 16'h1F00);
      for (k = 0; k < 8; k++) put(4, {5'h00, 3'(k), 5'h00, 3'(7 - k)});
      repeat (150) begin
         k = {$random(seed)} % 6;
         put(k, 16'($random(seed)));
         get(k);
      end
      @(posedge mclk);
      rst <= 1'b1;
      m = '{16'h8008, 16'h8808, 16'h8808, 16'h8808, 16'h0000};
      @(posedge mclk);
      #1;
      outs();
      @(posedge mclk);
      rst <= 1'b0;
      for (k = 0; k < 6; k++) get(k);
      results();
   end
   // about twenty-four times the expected run
   initial begin
      #1000000;
      fails++;
      results();
   end
endmodule // tb_top
